// File: tb/ltsr_top_properties.sv
/* Concurrent checks on the ltsr_top ports, bound below.
   Assumes one mclk domain with synchronous active-low rst_b. */
`timescale 1ns/1ps
module ltsr_top_properties
    import ltsr_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        wake_load_pulse,
    input wire logic [39:0] regulator_voltage_trim,
    input wire logic        converter_enable,
    input wire logic        converter_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        ##2 s_axi_bvalid;
    endsequence
    property p_trim_reset; $rose(rst_b) |-> regulator_voltage_trim == LTSR_TRIM_RESET; endproperty
    a_trim_reset: assert property (p_trim_reset) else $error("trim not at reset pattern");
    property p_en_reset; $rose(rst_b) |-> !converter_enable && !converter_busy; endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable not cleared by reset");
    property p_wr_answer; s_wr_taken |-> s_wr_answer; endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    // Enable moves only with a completed write, never on its own
    property p_en_hold; $past(rst_b) && $changed(converter_enable) |-> $rose(s_axi_bvalid); endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable changed without write");
    property p_trim_hold;
        $past(rst_b) && $changed(regulator_voltage_trim) |-> $rose(s_axi_bvalid) || $past(wake_load_pulse);
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("trim changed without cause");
    property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_stand: assert property (p_b_stand) else $error("write response dropped");
    property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_stand: assert property (p_r_stand) else $error("read data dropped");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_err_zero; s_axi_rvalid && s_axi_rresp == LTSR_RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
endmodule

bind ltsr_top ltsr_top_properties u_props (.mclk(mclk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wake_load_pulse(wake_load_pulse), .regulator_voltage_trim(regulator_voltage_trim),
    .converter_enable(converter_enable), .converter_busy(converter_busy));

// File: tb/ltsr_top_tb.sv
/* Self-checking bench for ltsr_top over AXI4-Lite.
   Assumes the checker is bound by its own file; protection bits tied. */
`timescale 1ns/1ps
module ltsr_top_tb;
    import ltsr_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic wlp = 1'b0, rdone = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [39:0] stored = 40'h0;
    logic [7:0] sup = 8'h0, tmp = 8'h0;
    logic [15:0] wk = 16'h0;
    wire logic awready, wready, bvalid, arready, rvalid, en, busy;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [39:0] trim;
    int err_count = 0, num_checks = 0;
    localparam logic [1:0] OK = LTSR_RESP_OKAY, ER = LTSR_RESP_SLVERR;
    ltsr_top DUT (.mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .wake_load_pulse(wlp), .stored_regulator_trim_word(stored),
        .reading_done(rdone), .latest_supply_reading(sup), .latest_temperature_reading(tmp),
        .converter_wakeup_readings(wk), .regulator_voltage_trim(trim), .converter_enable(en),
        .converter_busy(busy));
    always #5 mclk = ~mclk;
    task close_out;
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [39:0] s, input logic [39:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // Bready goes up with the request and stays up until bvalid is seen
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw;
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            #1;
            ta = awv && awready; tw = wv && wready;
            if (bvalid && bready) break;
            @(posedge mclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        if (n == 50) begin err_count++; close_out(); end
        chk(40'(bresp), 40'(er));
        @(posedge mclk);
        bready <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic tr;
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            #1;
            tr = arv && arready;
            if (rvalid && rready) break;
            @(posedge mclk);
            if (tr) arv <= 1'b0;
        end
        if (n == 50) begin err_count++; close_out(); end
        chk(40'(rdata), 40'(ed));
        chk(40'(rresp), 40'(er));
        @(posedge mclk);
        rready <= 1'b0;
    endtask
    task pulse_load;
        wlp <= 1'b1;
        @(posedge mclk);
        wlp <= 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task t_reset;
        rd(12'h0c0, 32'h88888888, OK);
        rd(12'h0c4, 32'h00000088, OK);
        chk(trim, LTSR_TRIM_RESET);
        rd(12'h000, 32'h0, OK);
    endtask
    task t_enable;
        wr(12'h000, 32'h1, OK);
        chk(40'(en), 40'h1);
        chk(40'(busy), 40'h1);
        repeat (LTSR_CONV_CYCLES - 10) @(posedge mclk);
        #1;
        chk(40'(busy), 40'h1);
        repeat (20) @(posedge mclk);
        #1;
        chk(40'(en), 40'h1);
        chk(40'(busy), 40'h0);
        wr(12'h000, 32'h0, OK);
        chk(40'(en), 40'h0);
    endtask
    task t_readings;
        sup <= 8'h5a; tmp <= 8'hc3; wk <= 16'hbeef; rdone <= 1'b1;
        @(posedge mclk);
        rdone <= 1'b0;
        rd(12'h00c, 32'h0000c35a, OK);
        rd(12'h018, 32'h0000beef, OK);
        rd(12'h020, 32'h0, OK);
    endtask
    task t_reserved;
        // The reserved file is only read; the write goes to another hole
        wr(12'h0a8, 32'hffffffff, ER);
        rd(12'h0a4, 32'h0, ER);
        wr(12'h000, 32'h00000001, OK);
        rd(12'h000, 32'h00000001, OK);
        chk(40'(en), 40'h1);
    endtask
    task t_trim;
        stored <= 40'h123456789a;
        pulse_load();
        chk(trim, LTSR_TRIM_RESET);
        // Software may also load the calibrated word itself
        wr(12'h0c0, 32'h3456789a, OK);
        wr(12'h0c4, 32'h00000012, OK);
        chk(trim, 40'h123456789a);
        // Mid-run reset brings back the default before the automatic load
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        chk(trim, LTSR_TRIM_RESET);
        wr(12'h100, 32'h00001000, OK);
        pulse_load();
        chk(trim, 40'h123456789a);
        rd(12'h0c4, 32'h00000012, OK);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_enable();
        t_readings();
        t_reserved();
        t_trim();
        close_out();
    end
endmodule

// File: verilog/ltsr_pkg.sv
/*
 * Package for the regulator trim and converter trigger register bank:
 * register offsets, field layout, reset values and bus answers.
 * Assumes a 32-bit AXI4-Lite register bus and a 100 MHz clock.
 */
package ltsr_pkg;

    // Printed offsets are not all multiples of four, so they are indices
    localparam logic [7:0]  LTSR_IDX_CONV_CTRL   = 8'h00;
    localparam logic [7:0]  LTSR_IDX_CONV_LATEST = 8'h03;
    localparam logic [7:0]  LTSR_IDX_CONV_WAKEUP = 8'h06;
    localparam logic [7:0]  LTSR_IDX_PG_CONTROL  = 8'h08;
    localparam logic [7:0]  LTSR_IDX_PG_STATUS   = 8'h09;
    localparam logic [7:0]  LTSR_IDX_PG_DELAY    = 8'h0b;
    localparam logic [7:0]  LTSR_IDX_PG_TEST     = 8'h0c;
    localparam logic [7:0]  LTSR_IDX_TRIM        = 8'h30;

    // Own words: upper trim byte, wake configuration, reserved file guard
    localparam logic [7:0]  LTSR_IDX_TRIM_HI     = 8'h31;
    localparam logic [7:0]  LTSR_IDX_WAKE_CFG    = 8'h40;
    localparam logic [7:0]  LTSR_IDX_RSVD_FILE   = 8'h29;

    localparam int          LTSR_ADDR_W          = 12;
    localparam int          LTSR_TRIM_W          = 40;
    localparam int          LTSR_CONV_CTRL_W     = 16;

    localparam logic [39:0] LTSR_TRIM_RESET      = 40'h8888888888;
    localparam logic [15:0] LTSR_CONV_CTRL_RESET = 16'h0000;
    localparam int          LTSR_CONV_EN_BIT     = 0;
    localparam int          LTSR_WAKE_LOAD_BIT   = 12;
    localparam logic [31:0] LTSR_WAKE_CFG_RESET  = 32'h00000000;

    // Time the converter needs per reading
    localparam real         LTSR_CONV_TIME_NS    = 2500.0;
    localparam real         LTSR_CLK_NS          = 10.0;
    localparam int          LTSR_CONV_CYCLES     = int'($ceil(LTSR_CONV_TIME_NS / LTSR_CLK_NS));

    localparam logic [1:0]  LTSR_RESP_OKAY       = 2'b00;
    localparam logic [1:0]  LTSR_RESP_SLVERR     = 2'b10;

endpackage

// File: verilog/ltsr_top.sv
/*
 * Register bank for the regulator voltage trim word and the transmit
 * calibration converter control, behind an AXI4-Lite slave.
 * Assumes stored trim word and converter readings arrive from logic
 * on mclk; the wake-up load request is a single-cycle pulse.
 */
// Decided for this implementation: the AXI4-Lite register port.
// Function
// - 40-bit read/write trim register resetting to 0x8888888888.
// - Trim register content drives the regulator voltage outputs.
// - Wake config bit 12 enables automatic copy of stored trim word.
// - Converter control at 0x00, readings 0x03 and 0x06, pulse regs after.
// - Converter control is 16-bit read/write, resetting to zero.
// - Bit 0 written one sets converter enable, zero clears it.
// - Latest readings hold supply in bits 7:0, temperature in 15:8.
`timescale 1ns/1ps
module ltsr_top
    import ltsr_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire logic [LTSR_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [LTSR_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   wake_load_pulse,
    input  wire logic [39:0]            stored_regulator_trim_word,
    input  wire logic                   reading_done,
    input  wire logic [7:0]             latest_supply_reading,
    input  wire logic [7:0]             latest_temperature_reading,
    input  wire logic [15:0]            converter_wakeup_readings,
    output logic [39:0]                 regulator_voltage_trim,
    output logic                        converter_enable,
    output logic                        converter_busy
);

    logic [39:0]            trim_reg, trim_next;
    logic [15:0]            conv_ctrl_reg, conv_ctrl_next;
    logic [31:0]            wake_cfg_reg, wake_cfg_next;
    logic [15:0]            latest_reg, latest_next;
    logic [8:0]             conv_cnt_reg, conv_cnt_next;
    logic                   aw_held_reg, aw_held_next;
    logic                   w_held_reg, w_held_next;
    logic [LTSR_ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0]            wdata_reg, wdata_next;
    logic [3:0]             wstrb_reg, wstrb_next;
    logic                   bvalid_reg, bvalid_next;
    logic [1:0]             bresp_reg, bresp_next;
    logic                   rvalid_reg, rvalid_next;
    logic [1:0]             rresp_reg, rresp_next;
    logic [31:0]            rdata_reg, rdata_next;

    logic                   wr_go;
    logic [7:0]             wr_idx;
    logic [7:0]             rd_idx;
    logic [31:0]            wmask;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    assign regulator_voltage_trim = trim_reg;
    assign converter_enable       = conv_ctrl_reg[LTSR_CONV_EN_BIT];
    assign converter_busy         = conv_cnt_reg != 9'h000;

    assign wr_go  = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_idx = awaddr_reg[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    assign wmask  = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    always_comb begin
        aw_held_next   = aw_held_reg;
        w_held_next    = w_held_reg;
        awaddr_next    = awaddr_reg;
        wdata_next     = wdata_reg;
        wstrb_next     = wstrb_reg;
        bvalid_next    = bvalid_reg;
        bresp_next     = bresp_reg;
        rvalid_next    = rvalid_reg;
        rresp_next     = rresp_reg;
        rdata_next     = rdata_reg;
        trim_next      = trim_reg;
        conv_ctrl_next = conv_ctrl_reg;
        wake_cfg_next  = wake_cfg_reg;
        latest_next    = latest_reg;
        conv_cnt_next  = conv_cnt_reg;

        // Address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end

        // Busy window counts the minimum converter time after enable
        if (!conv_ctrl_reg[LTSR_CONV_EN_BIT] || reading_done) begin
            conv_cnt_next = 9'h000;
        end else if (conv_cnt_reg != 9'h000) begin
            conv_cnt_next = conv_cnt_reg - 9'h001;
        end

        if (reading_done) begin
            latest_next = {latest_temperature_reading, latest_supply_reading};
        end

        if (wake_load_pulse && wake_cfg_reg[LTSR_WAKE_LOAD_BIT]) begin
            trim_next = stored_regulator_trim_word;
        end

        if (wr_go) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = LTSR_RESP_OKAY;
            unique case (wr_idx)
                LTSR_IDX_CONV_CTRL: begin
                    // Reserved bits are stored as written; only bit 0 acts
                    conv_ctrl_next = (conv_ctrl_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
                    if (!conv_ctrl_reg[LTSR_CONV_EN_BIT] && wstrb_reg[0] && wdata_reg[LTSR_CONV_EN_BIT]) begin
                        conv_cnt_next = 9'(LTSR_CONV_CYCLES);
                    end
                end
                LTSR_IDX_TRIM: begin
                    trim_next[31:0] = (trim_reg[31:0] & ~wmask) | (wdata_reg & wmask);
                end
                LTSR_IDX_TRIM_HI: begin
                    if (wstrb_reg[0]) begin
                        trim_next[39:32] = wdata_reg[7:0];
                    end
                end
                LTSR_IDX_WAKE_CFG: begin
                    wake_cfg_next = (wake_cfg_reg & ~wmask) | (wdata_reg & wmask);
                end
                // Read-only readings and unbacked pulse-generator words ignore writes
                LTSR_IDX_CONV_LATEST, LTSR_IDX_CONV_WAKEUP, LTSR_IDX_PG_CONTROL,
                LTSR_IDX_PG_STATUS, LTSR_IDX_PG_DELAY, LTSR_IDX_PG_TEST: begin
                end
                default: begin
                    bresp_next = LTSR_RESP_SLVERR;
                end
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = LTSR_RESP_OKAY;
            unique case (rd_idx)
                LTSR_IDX_CONV_CTRL:   rdata_next = {16'h0000, conv_ctrl_reg};
                LTSR_IDX_CONV_LATEST: rdata_next = {16'h0000, latest_reg};
                LTSR_IDX_CONV_WAKEUP: rdata_next = {16'h0000, converter_wakeup_readings};
                LTSR_IDX_PG_CONTROL, LTSR_IDX_PG_STATUS,
                LTSR_IDX_PG_DELAY, LTSR_IDX_PG_TEST: rdata_next = 32'h00000000;
                LTSR_IDX_TRIM:        rdata_next = trim_reg[31:0];
                LTSR_IDX_TRIM_HI:     rdata_next = {24'h000000, trim_reg[39:32]};
                LTSR_IDX_WAKE_CFG:    rdata_next = wake_cfg_reg;
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = LTSR_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            trim_reg      <= LTSR_TRIM_RESET;
            conv_ctrl_reg <= LTSR_CONV_CTRL_RESET;
            wake_cfg_reg  <= LTSR_WAKE_CFG_RESET;
            latest_reg    <= 16'h0000;
            conv_cnt_reg  <= 9'h000;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= 32'h00000000;
            wstrb_reg     <= 4'h0;
            bvalid_reg    <= 1'b0;
            bresp_reg     <= LTSR_RESP_OKAY;
            rvalid_reg    <= 1'b0;
            rresp_reg     <= LTSR_RESP_OKAY;
            rdata_reg     <= 32'h00000000;
        end else begin
            trim_reg      <= trim_next;
            conv_ctrl_reg <= conv_ctrl_next;
            wake_cfg_reg  <= wake_cfg_next;
            latest_reg    <= latest_next;
            conv_cnt_reg  <= conv_cnt_next;
            aw_held_reg   <= aw_held_next;
            w_held_reg    <= w_held_next;
            awaddr_reg    <= awaddr_next;
            wdata_reg     <= wdata_next;
            wstrb_reg     <= wstrb_next;
            bvalid_reg    <= bvalid_next;
            bresp_reg     <= bresp_next;
            rvalid_reg    <= rvalid_next;
            rresp_reg     <= rresp_next;
            rdata_reg     <= rdata_next;
        end
    end

endmodule
